// ===== hdl/io_line_pkg.sv
// constants, types and helpers shared by the i/o line control block
package io_line_pkg;

  // ==========================================================
  // geometry
  localparam int LINES = 32;
  localparam int DIV_W = 14;
  localparam int CLK_PERIOD_NS = 10;

  // ==========================================================
  // port instances, each a copy of the map at its own base
  localparam logic [31:0] INST_A_BASE = 32'hfffff400;
  localparam logic [31:0] INST_STRIDE = 32'h00000200;

  // ==========================================================
  // register addresses as seen by port_instance_a
  localparam logic [31:0] ADDR_PULL_UP_DISABLE = 32'hfffff460;
  localparam logic [31:0] ADDR_PULL_UP_ENABLE = 32'hfffff464;
  localparam logic [31:0] ADDR_PULL_UP_STATUS = 32'hfffff468;
  localparam logic [31:0] ADDR_FUNC_SEL_LOW = 32'hfffff470;
  localparam logic [31:0] ADDR_FUNC_SEL_HIGH = 32'hfffff474;
  localparam logic [31:0] ADDR_FILT_SLOW_DIS = 32'hfffff480;
  localparam logic [31:0] ADDR_FILT_SLOW_EN = 32'hfffff484;
  localparam logic [31:0] ADDR_FILT_SEL_STATUS = 32'hfffff488;
  localparam logic [31:0] ADDR_DEBOUNCE_DIV = 32'hfffff48c;
  localparam logic [31:0] ADDR_PULL_DOWN_DIS = 32'hfffff490;
  localparam logic [31:0] ADDR_PULL_DOWN_EN = 32'hfffff494;
  localparam logic [31:0] ADDR_PULL_DOWN_STATUS = 32'hfffff498;
  localparam logic [31:0] ADDR_OUT_WRITE_EN = 32'hfffff4a0;
  localparam logic [31:0] ADDR_OUT_WRITE_DIS = 32'hfffff4a4;
  localparam logic [31:0] ADDR_OUT_WRITE_STATUS = 32'hfffff4a8;
  localparam logic [31:0] ADDR_WRITE_PROTECT = 32'hfffff4e4;

  // ==========================================================
  // field positions and reset values
  localparam int WP_ON_BIT = 0;
  localparam logic [31:0] RST_PULL_UP = 32'hffffffff;
  localparam logic [31:0] RST_PULL_DOWN = 32'h00000000;
  localparam logic [31:0] RST_FUNC_SEL = 32'h00000000;
  localparam logic [31:0] RST_DEBOUNCE_SEL = 32'h00000000;
  localparam logic [31:0] RST_OUT_WRITE = 32'h00000000;
  localparam logic [DIV_W-1:0] RST_DIV = 14'h0000;

  // ==========================================================
  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ==========================================================
  // peripheral function of one line
  typedef enum logic [1:0] {FN_A, FN_B, FN_C, FN_D} periph_fn_t;

  // high select bit picks the pair, low bit the member of the pair
  function automatic periph_fn_t periph_fn(input logic hi, input logic lo);
    periph_fn = periph_fn_t'({hi, lo});
  endfunction : periph_fn

endpackage : io_line_pkg

// ===== hdl/io_line_filter.sv
// per-line glitch / debounce input filter
`timescale 1ns/1ps
module io_line_filter
  import io_line_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] debounce_sel_i,
  // lines
  input wire logic [WIDTH-1:0] line_i,
  output logic [WIDTH-1:0] line_o
);

  logic [WIDTH-1:0] glitch_r;
  logic [WIDTH-1:0] sample_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] stable_nxt;
  logic [WIDTH-1:0] out_nxt;

  // ==========================================================
  // a level is accepted only when two half-period samples agree
  assign stable_nxt = tick_i ? ((line_i & ~(line_i ^ sample_r)) |
                                (stable_r & (line_i ^ sample_r)))
                             : stable_r;
  // synchronous sampling already hides anything under half a clock
  assign out_nxt = (debounce_sel_i & stable_r) |
                   (~debounce_sel_i & glitch_r);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      glitch_r <= '0;
      sample_r <= '0;
      stable_r <= '0;
      line_o <= '0;
    end else begin
      glitch_r <= line_i;
      sample_r <= tick_i ? line_i : sample_r;
      stable_r <= stable_nxt;
      line_o <= out_nxt;
    end
  end

  // ==========================================================
  a_deb_only_tick: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !tick_i |=> $stable(stable_r))
    else $error("debounced level moved without a divided tick");

endmodule : io_line_filter

// ===== hdl/io_line_ctrl.sv
// ahb-lite register block for pad pulls, function select and input filter
//
// How it works
// - a one written to pull_up_enable turns that line's pull-up on.
// - pull_up_status reads zero for an active pull-up, one for an off one.
// - function_select_high and _low pick A, B (high 0) or C, D (high 1).
// - select, pull-up, pull-down and output-write writes are dropped while protected.
// - a one in filter_slow_clock_disable puts the line on the glitch filter.
// - a one in filter_slow_clock_enable puts the line on the debouncer.
// - filter_selection_status reads zero for glitch, one for debounce.
// - debounce_divider sets the half period to (field+1) slow-clock periods.
// - a one in pull_down_disable turns that line's pull-down off.
// - a one in pull_down_enable turns that line's pull-down on.
// - pull_down_status reads zero for an active pull-down, one otherwise.
// - four instances sit 0x200 apart, bit n of each register except divider and protect is line n.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module io_line_ctrl
  import io_line_pkg::*;
#(
  parameter int INSTANCE = 0,
  parameter int WIDTH = LINES
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // slow clock, sampled as a plain synchronous input
  input wire logic SLOW_CLK_I,
  // pads
  input wire logic [WIDTH-1:0] PAD_IN_I,
  output logic [WIDTH-1:0] PAD_FILTERED_O,
  output logic [WIDTH-1:0] PULL_UP_ON_O,
  output logic [WIDTH-1:0] PULL_DOWN_ON_O,
  output logic [WIDTH-1:0] FUNC_SEL_LOW_O,
  output logic [WIDTH-1:0] FUNC_SEL_HIGH_O,
  output logic [WIDTH-1:0] OUT_WRITE_ON_O
);

  // ==========================================================
  // address decode
  localparam logic [31:0] BASE = INST_A_BASE +
                                 INST_STRIDE * 32'(INSTANCE);

  function automatic logic hit(input logic [31:0] off,
                               input logic [31:0] reg_addr);
    hit = (off == (reg_addr - INST_A_BASE));
  endfunction : hit

  logic [31:0] addr_off;
  logic addr_fire;
  logic wr_pend_r;
  logic [31:0] wr_off_r;
  logic wr_fire;
  logic [WIDTH-1:0] wdata;

  assign addr_fire = HSEL_I & HREADY_I & HTRANS_I[1];
  assign addr_off = HADDR_I - BASE;
  assign wr_fire = wr_pend_r;
  assign wdata = HWDATA_I[WIDTH-1:0];

  // ==========================================================
  // state
  logic [WIDTH-1:0] pu_r;
  logic [WIDTH-1:0] pd_r;
  logic [WIDTH-1:0] fsel_lo_r;
  logic [WIDTH-1:0] fsel_hi_r;
  logic [WIDTH-1:0] deb_sel_r;
  logic [WIDTH-1:0] ow_r;
  logic [DIV_W-1:0] div_r;
  logic wp_on_r;
  logic [31:0] hrdata_r;

  logic [WIDTH-1:0] pu_nxt;
  logic [WIDTH-1:0] pd_nxt;
  logic [WIDTH-1:0] fsel_lo_nxt;
  logic [WIDTH-1:0] fsel_hi_nxt;
  logic [WIDTH-1:0] deb_sel_nxt;
  logic [WIDTH-1:0] ow_nxt;
  logic [DIV_W-1:0] div_nxt;
  logic wp_on_nxt;
  logic [31:0] hrdata_nxt;

  // ==========================================================
  // write strobes in the data phase
  logic w_pu_dis;
  logic w_pu_en;
  logic w_fs_lo;
  logic w_fs_hi;
  logic w_filt_dis;
  logic w_filt_en;
  logic w_div;
  logic w_pd_dis;
  logic w_pd_en;
  logic w_ow_en;
  logic w_ow_dis;
  logic w_wp;
  logic unlocked;

  assign unlocked = ~wp_on_r;
  assign w_pu_dis = wr_fire & unlocked & hit(wr_off_r, ADDR_PULL_UP_DISABLE);
  assign w_pu_en = wr_fire & unlocked & hit(wr_off_r, ADDR_PULL_UP_ENABLE);
  assign w_fs_lo = wr_fire & unlocked &
                   hit(wr_off_r, ADDR_FUNC_SEL_LOW);
  assign w_fs_hi = wr_fire & unlocked &
                   hit(wr_off_r, ADDR_FUNC_SEL_HIGH);
  assign w_filt_dis = wr_fire & hit(wr_off_r, ADDR_FILT_SLOW_DIS);
  assign w_filt_en = wr_fire & hit(wr_off_r, ADDR_FILT_SLOW_EN);
  assign w_div = wr_fire & hit(wr_off_r, ADDR_DEBOUNCE_DIV);
  assign w_pd_dis = wr_fire & unlocked &
                    hit(wr_off_r, ADDR_PULL_DOWN_DIS);
  assign w_pd_en = wr_fire & unlocked &
                   hit(wr_off_r, ADDR_PULL_DOWN_EN);
  assign w_ow_en = wr_fire & unlocked &
                   hit(wr_off_r, ADDR_OUT_WRITE_EN);
  assign w_ow_dis = wr_fire & unlocked & hit(wr_off_r, ADDR_OUT_WRITE_DIS);
  // the protect bit itself must stay writable or it could never be cleared
  assign w_wp = wr_fire & hit(wr_off_r, ADDR_WRITE_PROTECT);

  // ==========================================================
  // next state: in the set/clear pairs ones act, zeros leave the line alone; select, divider and protect take the written value
  assign pu_nxt = w_pu_en ? (pu_r | wdata)
                : w_pu_dis ? (pu_r & ~wdata) : pu_r;
  assign pd_nxt = w_pd_en ? (pd_r | wdata)
                : w_pd_dis ? (pd_r & ~wdata) : pd_r;
  assign deb_sel_nxt = w_filt_en ? (deb_sel_r | wdata)
                     : w_filt_dis ? (deb_sel_r & ~wdata)
                     : deb_sel_r;
  assign ow_nxt = w_ow_en ? (ow_r | wdata)
                : w_ow_dis ? (ow_r & ~wdata) : ow_r;
  assign fsel_lo_nxt = w_fs_lo ? wdata : fsel_lo_r;
  assign fsel_hi_nxt = w_fs_hi ? wdata : fsel_hi_r;
  assign div_nxt = w_div ? HWDATA_I[DIV_W-1:0] : div_r;
  assign wp_on_nxt = w_wp ? HWDATA_I[WP_ON_BIT] : wp_on_r;

  // ==========================================================
  // read mux, captured in the address phase; the master idles during
  // a write data phase, so a read never races a register update
  logic [31:0] rd_val;
  logic [31:0] rd_off;
  assign rd_off = addr_off;
  assign rd_val =
      hit(rd_off, ADDR_PULL_UP_STATUS) ? 32'(~pu_r)
    : hit(rd_off, ADDR_FUNC_SEL_LOW) ? 32'(fsel_lo_r)
    : hit(rd_off, ADDR_FUNC_SEL_HIGH) ? 32'(fsel_hi_r)
    : hit(rd_off, ADDR_FILT_SEL_STATUS) ? 32'(deb_sel_r)
    : hit(rd_off, ADDR_DEBOUNCE_DIV) ? 32'(div_r)
    : hit(rd_off, ADDR_PULL_DOWN_STATUS) ? 32'(~pd_r)
    : hit(rd_off, ADDR_OUT_WRITE_STATUS) ? 32'(ow_r)
    : hit(rd_off, ADDR_WRITE_PROTECT) ? 32'(wp_on_r)
    : 32'h00000000;
  assign hrdata_nxt = (addr_fire & ~HWRITE_I) ? rd_val : hrdata_r;

  // ==========================================================
  // registers
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wr_pend_r <= 1'b0;
      wr_off_r <= 32'h00000000;
      hrdata_r <= 32'h00000000;
    end else begin
      // only whole-word writes are taken
      wr_pend_r <= addr_fire & HWRITE_I & (HSIZE_I == HSIZE_WORD);
      wr_off_r <= addr_fire ? addr_off : wr_off_r;
      hrdata_r <= hrdata_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pu_r <= RST_PULL_UP[WIDTH-1:0];
      pd_r <= RST_PULL_DOWN[WIDTH-1:0];
      fsel_lo_r <= RST_FUNC_SEL[WIDTH-1:0];
      fsel_hi_r <= RST_FUNC_SEL[WIDTH-1:0];
      deb_sel_r <= RST_DEBOUNCE_SEL[WIDTH-1:0];
      ow_r <= RST_OUT_WRITE[WIDTH-1:0];
      div_r <= RST_DIV;
      wp_on_r <= 1'b0;
    end else begin
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      fsel_lo_r <= fsel_lo_nxt;
      fsel_hi_r <= fsel_hi_nxt;
      deb_sel_r <= deb_sel_nxt;
      ow_r <= ow_nxt;
      div_r <= div_nxt;
      wp_on_r <= wp_on_nxt;
    end
  end

  // ==========================================================
  // divided slow clock: a tick every div+1 slow edges is one half
  // period of 2*(div+1) slow periods
  logic slow_q_r;
  logic slow_rise;
  logic [DIV_W-1:0] slow_cnt_r;
  logic [DIV_W-1:0] slow_cnt_nxt;
  logic half_tick;

  assign slow_rise = SLOW_CLK_I & ~slow_q_r;
  assign half_tick = slow_rise & (slow_cnt_r >= div_r);
  assign slow_cnt_nxt = half_tick ? '0
                      : slow_rise ? slow_cnt_r + 1'b1 : slow_cnt_r;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      slow_q_r <= 1'b0;
      slow_cnt_r <= '0;
    end else begin
      slow_q_r <= SLOW_CLK_I;
      slow_cnt_r <= slow_cnt_nxt;
    end
  end

  io_line_filter #(.WIDTH(WIDTH)) u_filter (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .tick_i(half_tick),
    .debounce_sel_i(deb_sel_r),
    .line_i(PAD_IN_I),
    .line_o(PAD_FILTERED_O)
  );

  // ==========================================================
  // outputs
  assign HRDATA_O = hrdata_r;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign PULL_UP_ON_O = pu_r;
  assign PULL_DOWN_ON_O = pd_r;
  assign FUNC_SEL_LOW_O = fsel_lo_r;
  assign FUNC_SEL_HIGH_O = fsel_hi_r;
  assign OUT_WRITE_ON_O = ow_r;

  // ==========================================================
  // checks
  periph_fn_t fn_line0;
  assign fn_line0 = periph_fn(fsel_hi_r[0], fsel_lo_r[0]);

  sequence s_rd_addr(logic [31:0] a);
    addr_fire && !HWRITE_I && hit(addr_off, a);
  endsequence

  sequence s_wr_data(logic [31:0] a);
    wr_fire && hit(wr_off_r, a);
  endsequence

  a_pu_enable_set: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_wr_data(ADDR_PULL_UP_ENABLE) ##0 unlocked |=>
    ((pu_r & $past(wdata)) == $past(wdata)) &&
    ((pu_r & ~$past(wdata)) == ($past(pu_r) & ~$past(wdata))))
    else $error("pull-up enable write misapplied");

  a_pu_status_inv: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_rd_addr(ADDR_PULL_UP_STATUS) |=> HRDATA_O == 32'(~$past(pu_r)))
    else $error("pull-up status not inverted state");

  a_fn_line_map: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    fn_line0 == (FUNC_SEL_HIGH_O[0] ? (FUNC_SEL_LOW_O[0] ? FN_D : FN_C)
                 : (FUNC_SEL_LOW_O[0] ? FN_B : FN_A)))
    else $error("line 0 function decode wrong");

  a_wp_blocks_pd: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    wr_fire && wp_on_r && (hit(wr_off_r, ADDR_PULL_DOWN_EN) ||
    hit(wr_off_r, ADDR_PULL_DOWN_DIS) || hit(wr_off_r, ADDR_FUNC_SEL_LOW) ||
    hit(wr_off_r, ADDR_FUNC_SEL_HIGH) || hit(wr_off_r, ADDR_OUT_WRITE_EN))
    |=> $stable(pd_r) && $stable(fsel_lo_r) && $stable(fsel_hi_r) &&
    $stable(ow_r))
    else $error("protected write changed state");

  a_glitch_select: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_wr_data(ADDR_FILT_SLOW_DIS) |=>
    (deb_sel_r & $past(wdata)) == '0)
    else $error("glitch filter not selected");

  a_deb_select: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_wr_data(ADDR_FILT_SLOW_EN) |=>
    (deb_sel_r & $past(wdata)) == $past(wdata))
    else $error("debounce filter not selected");

  a_filt_status: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_rd_addr(ADDR_FILT_SEL_STATUS) |=> HRDATA_O == 32'($past(deb_sel_r)))
    else $error("filter status mismatch");

  a_div_upper_zero: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_rd_addr(ADDR_DEBOUNCE_DIV) |=>
    HRDATA_O[31:DIV_W] == '0 && HRDATA_O[DIV_W-1:0] == $past(div_r))
    else $error("divider readback wrong");

  a_div_count_bound: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    slow_rise && slow_cnt_r < div_r |=> slow_cnt_r == $past(slow_cnt_r) + 1)
    else $error("slow clock divider skipped");

  a_pd_disable: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_wr_data(ADDR_PULL_DOWN_DIS) ##0 unlocked |=>
    (pd_r & $past(wdata)) == '0)
    else $error("pull-down not disabled");

  a_pd_enable: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_wr_data(ADDR_PULL_DOWN_EN) ##0 unlocked |=>
    (pd_r & $past(wdata)) == $past(wdata))
    else $error("pull-down not enabled");

  a_pd_status_inv: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_rd_addr(ADDR_PULL_DOWN_STATUS) |=> HRDATA_O == 32'(~$past(pd_r)))
    else $error("pull-down status not inverted state");

  // a foreign write lands at the end of its data phase, so look one later
  a_other_inst_quiet: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    addr_fire && HWRITE_I && addr_off >= INST_STRIDE |=> ##1
    $stable(pu_r) && $stable(pd_r) && $stable(fsel_lo_r) &&
    $stable(fsel_hi_r) && $stable(deb_sel_r) && $stable(div_r) &&
    $stable(ow_r))
    else $error("foreign instance address decoded");

  a_pu_one_clock: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    s_wr_data(ADDR_PULL_UP_DISABLE) ##0 unlocked && (wdata & pu_r) != '0
    |=> $changed(PULL_UP_ON_O))
    else $error("pull-up disable took more than one clock");

endmodule : io_line_ctrl

// ===== tb/io_line_ctrl_test.sv
// self-checking testbench for the i/o line register and filter block
`timescale 1ns/1ps
module io_line_ctrl_test;
  import io_line_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic slow = 1'b0;
  logic [1:0] scnt = 2'h0;
  logic [31:0] pad = 32'h00000000;
  logic [31:0] filt, pu_on, pd_on, fs_lo, fs_hi, ow_on;
  logic [31:0] q;
  int n_mismatch = 0;
  int cmp_count = 0;

  // ==========================================================
  // clocks: slow clock toggles every 4 cycles, period 8 cycles
  always #5 clk = ~clk;
  always @(posedge clk) begin
    scnt <= scnt + 2'h1;
    if (scnt == 2'h3) begin
      slow <= ~slow;
    end
  end

  // instance b, so instance a addresses must be unmapped here
  io_line_ctrl #(.INSTANCE(1), .WIDTH(LINES)) uut (
    .CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .SLOW_CLK_I(slow),
    .PAD_IN_I(pad), .PAD_FILTERED_O(filt), .PULL_UP_ON_O(pu_on),
    .PULL_DOWN_ON_O(pd_on), .FUNC_SEL_LOW_O(fs_lo),
    .FUNC_SEL_HIGH_O(fs_hi), .OUT_WRITE_ON_O(ow_on)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] at(input logic [31:0] a);
    return a + INST_STRIDE;
  endfunction : at

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // a wait that never ends is cut short here
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (hready !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t bus never ready", $time);
      finish_test();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q, exp, "read back");
  endtask : rd

  // let the last write land on the pins
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(pu_on, RST_PULL_UP, "pull-up reset");
    rd(at(ADDR_PULL_UP_STATUS), ~RST_PULL_UP);
    rd(at(ADDR_PULL_DOWN_STATUS), ~RST_PULL_DOWN);
    rd(at(ADDR_FILT_SEL_STATUS), RST_DEBOUNCE_SEL);
    rd(at(ADDR_DEBOUNCE_DIV), 32'h00000000);
  endtask : t_reset

  task automatic t_pulls;
    wr(at(ADDR_PULL_UP_DISABLE), 32'h0000ff00);
    wr(at(ADDR_PULL_UP_ENABLE), 32'h00000f00);
    rd(at(ADDR_PULL_UP_STATUS), 32'h0000f000);
    settle();
    chk(pu_on, 32'hffff0fff, "pull-up pins");
    wr(at(ADDR_PULL_DOWN_EN), 32'ha5a5a5a5);
    wr(at(ADDR_PULL_DOWN_DIS), 32'h00000005);
    rd(at(ADDR_PULL_DOWN_STATUS), 32'h5a5a5a5f);
    settle();
    chk(pd_on, 32'ha5a5a5a0, "pull-down pins");
  endtask : t_pulls

  task automatic t_func;
    periph_fn_t want [4];
    want = '{FN_A, FN_B, FN_C, FN_D};
    wr(at(ADDR_FUNC_SEL_LOW), 32'haaaaaaaa);
    wr(at(ADDR_FUNC_SEL_HIGH), 32'hcccccccc);
    rd(at(ADDR_FUNC_SEL_LOW), 32'haaaaaaaa);
    rd(at(ADDR_FUNC_SEL_HIGH), 32'hcccccccc);
    settle();
    for (int i = 0; i < 4; i++) begin
      chk({30'h0, fs_hi[i], fs_lo[i]}, {30'h0, want[i]}, "function");
    end
  endtask : t_func

  task automatic t_protect;
    wr(at(ADDR_WRITE_PROTECT), 32'h00000001);
    wr(at(ADDR_FUNC_SEL_LOW), 32'h00000000);
    wr(at(ADDR_FUNC_SEL_HIGH), 32'h00000000);
    wr(at(ADDR_PULL_DOWN_EN), 32'hffffffff);
    wr(at(ADDR_OUT_WRITE_EN), 32'hffffffff);
    wr(at(ADDR_PULL_UP_DISABLE), 32'hffffffff);
    rd(at(ADDR_WRITE_PROTECT), 32'h00000001);
    rd(at(ADDR_FUNC_SEL_LOW), 32'haaaaaaaa);
    rd(at(ADDR_FUNC_SEL_HIGH), 32'hcccccccc);
    settle();
    chk(pd_on, 32'ha5a5a5a0, "protected pull-down");
    chk(ow_on, 32'h00000000, "protected output write");
    chk(pu_on, 32'hffff0fff, "protected pull-up");
    wr(at(ADDR_WRITE_PROTECT), 32'h00000000);
    wr(at(ADDR_OUT_WRITE_EN), 32'h0000ff00);
    wr(at(ADDR_PULL_DOWN_DIS), 32'hffffffff);
    settle();
    chk(ow_on, 32'h0000ff00, "output write open");
    chk(pd_on, 32'h00000000, "pull-down open");
    wr(at(ADDR_OUT_WRITE_DIS), 32'h00000f00);
    rd(at(ADDR_OUT_WRITE_STATUS), 32'h0000f000);
  endtask : t_protect

  task automatic t_map;
    rd(ADDR_PULL_UP_STATUS, 32'h00000000);
    wr(ADDR_PULL_DOWN_EN, 32'hffffffff);
    settle();
    chk(pd_on, 32'h00000000, "other instance write");
    wr(at(ADDR_DEBOUNCE_DIV), 32'hffffffff);
    rd(at(ADDR_DEBOUNCE_DIV), 32'((1 << DIV_W) - 1));
    wr(at(ADDR_DEBOUNCE_DIV), 32'h00000001);
    wr(at(ADDR_FILT_SLOW_EN), 32'h0000000f);
    wr(at(ADDR_FILT_SLOW_DIS), 32'h00000003);
    rd(at(ADDR_FILT_SEL_STATUS), 32'h0000000c);
  endtask : t_map

  // line 4 on the glitch filter: output follows the pad two edges later
  task automatic t_glitch;
    @(posedge clk);
    pad[4] <= 1'b1;
    settle();
    chk({31'h0, filt[4]}, 32'h0, "glitch early");
    settle();
    chk({31'h0, filt[4]}, 32'h1, "glitch pass");
  endtask : t_glitch

  // line 2 debounced, divider 1: half period 16 clk cycles
  task automatic t_debounce;
    int k;
    @(posedge clk);
    pad[2] <= 1'b1;
    repeat (3) @(posedge clk);
    pad[2] <= 1'b0;
    for (k = 0; k < 60; k++) begin
      settle();
      chk({31'h0, filt[2]}, 32'h0, "short pulse passed");
    end
    @(posedge clk);
    pad[2] <= 1'b1;
    k = 0;
    while (filt[2] !== 1'b1 && k < 100) begin
      settle();
      k++;
    end
    // two agreeing ticks 16 cycles apart, plus sampling and output stages
    chk({31'h0, (k >= 16 && k <= 34)}, 32'h1, "debounce delay");
  endtask : t_debounce

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pulls();
    t_func();
    t_protect();
    t_map();
    t_glitch();
    t_debounce();
    finish_test();
  end

endmodule : io_line_ctrl_test
